// >>> inc/byte_enable_out_pkg.sv
// package for the parallel master bus engine: field layouts, encodings, carriers
// assumes one core clock; configuration arrives as plain ports from the cpu side
//
// Functional notes
// - mux select 00 keeps address and data apart
// - mux 01 low address on data pins
// - partial mux adds one address cycle
// - full mux adds low then high address cycles
// - select bits forced zero in muxed high byte
// - one select line shares address high bit 6
// - select bits excluded from address stepping
// - step mode picks increment, decrement or hold
// - address steps once, when operation completes
// - select bits step only when used as address
// - setup waits before strobe
// - strobe waits hold strobe active
// - zero strobe wait disables setup and hold waits
// - hold waits after strobe
// - read of low input starts bus read
// - wide mode read does two bus reads
// - software sees previous read result
// - low input write starts bus write
// - busy set for all cycles but last when strobe wait is zero, else for every cycle
// - requests ignored while busy
// - completion pulse per finished operation, one for both wide beats
// - address muxing only in master modes
// - mode 1 direction plus enable, mode 2 separate strobes
// - low byte first, byte enable on high byte
// - per-pin programmable control polarity, except one shared bit for both address latch pins
package byte_enable_out_pkg;

  localparam logic [1:0] BYTE_ENABLE_OUT_MUX_DEMUX   = 2'h0;
  localparam logic [1:0] BYTE_ENABLE_OUT_MUX_PARTIAL = 2'h1;
  localparam logic [1:0] BYTE_ENABLE_OUT_MUX_FULL    = 2'h2;

  localparam logic [1:0] BYTE_ENABLE_OUT_STEP_NONE   = 2'h0;
  localparam logic [1:0] BYTE_ENABLE_OUT_STEP_INC    = 2'h1;
  localparam logic [1:0] BYTE_ENABLE_OUT_STEP_DEC    = 2'h2;

  localparam logic [1:0] BYTE_ENABLE_OUT_MODE_MASTER1 = 2'h3;
  localparam logic [1:0] BYTE_ENABLE_OUT_MODE_MASTER2 = 2'h2;

  // chip-select function field value that turns address bit 14 into the select line
  localparam logic [1:0] BYTE_ENABLE_OUT_CSF_SELECT  = 2'h2;
  localparam int         BYTE_ENABLE_OUT_SELECT_BIT  = 14;
  localparam logic [15:0] BYTE_ENABLE_OUT_ADDR_RESET = 16'h0000;
  localparam logic [15:0] BYTE_ENABLE_OUT_SEL_MASK   = 16'hC000;

  typedef struct packed {
    logic [1:0] mode;
    logic       wide;
    logic [1:0] step;
    logic [1:0] mux;
    logic [1:0] csf;
    logic       al_pol;
    logic       cs_pol;
    logic       be_pol;
    logic       wr_pol;
    logic       rd_pol;
    logic [1:0] wait_setup;
    logic [3:0] wait_strobe;
    logic [1:0] wait_hold;
  } byte_enable_out_cfg_type;

  typedef struct packed {
    logic read_strobe_out;
    logic write_strobe_out;
    logic byte_enable_out;
    logic port_select_line;
    logic addr_pin_zero;
    logic addr_pin_one;
  } byte_enable_out_ctl_type;

endpackage : byte_enable_out_pkg

// >>> rtl/byte_enable_out_data_store.sv
// input data store: low and high bytes captured from bus reads
// assumes only the engine writes, one byte per cycle
`timescale 1ns/1ps
`default_nettype none
module byte_enable_out_data_store
  import byte_enable_out_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic             wr_sel,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] rd_low,
  output var  logic [WIDTH-1:0] rd_high
);

  logic [WIDTH-1:0] mem [2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else if (wr_en)
      mem[wr_sel] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_low  <= '0;
      rd_high <= '0;
    end
    else
    begin
      rd_low  <= mem[0];
      rd_high <= mem[1];
    end
  end

endmodule : byte_enable_out_data_store
`default_nettype wire

// >>> rtl/byte_enable_out_engine.sv
// parallel master bus engine: one cpu access of the low input byte runs a bus cycle
// assumes cpu strobes are one-cycle pulses synchronous to CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module byte_enable_out_engine
  import byte_enable_out_pkg::*;
(
  // clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         SYS_RST,
  // configuration
  input  wire logic         PORT_ENABLE,
  input  wire byte_enable_out_cfg_type CFG,
  // cpu access to input data and address
  input  wire logic         IN_LOW_READ,
  input  wire logic         IN_LOW_WRITE,
  input  wire logic         IN_HIGH_WRITE,
  input  wire logic [7:0]   CPU_WDATA,
  input  wire logic         ADDR_LOAD,
  input  wire logic [15:0]  ADDR_WDATA,
  // status to cpu
  output logic [7:0]        INPUT_DATA_LOW,
  output logic [7:0]        INPUT_DATA_HIGH,
  output logic [15:0]       ADDR_VALUE,
  output logic              BUSY,
  output logic              CYCLE_DONE,
  // bus pins
  input  wire logic [7:0]   DATA_IN,
  output logic [7:0]        DATA_OUT,
  output logic              DATA_OE,
  output logic [15:0]       ADDR_OUT,
  output byte_enable_out_ctl_type      CTL
);

  typedef enum logic [2:0] {S_IDLE, S_ALO, S_AHI, S_SETUP, S_STROBE, S_HOLD} byte_enable_out_state_type;

  byte_enable_out_state_type state;
  byte_enable_out_state_type next_state;
  logic [3:0]     cnt;
  logic           is_read;
  logic           beat;
  logic [15:0]    addr;
  logic [7:0]     out_low;
  logic [7:0]     out_high;
  logic           st_wr_en;
  logic           st_wr_sel;
  logic [7:0]     st_wr_data;
  logic           start;
  logic           master;
  logic           sel_used;
  logic           last_cycle;
  logic           beat_done;
  logic           op_done;

  function automatic byte_enable_out_state_type first_state(input logic [1:0] mux, input logic is_master);
    if (is_master && mux == BYTE_ENABLE_OUT_MUX_PARTIAL)
      return S_ALO;
    else if (is_master && mux == BYTE_ENABLE_OUT_MUX_FULL)
      return S_ALO;
    else if (CFG.wait_strobe != 4'h0)
      return S_SETUP;
    else
      return S_STROBE;
  endfunction : first_state

  assign master   = PORT_ENABLE && CFG.mode[1];
  assign sel_used = CFG.csf == BYTE_ENABLE_OUT_CSF_SELECT;
  assign start    = master && state == S_IDLE && !BUSY && (IN_LOW_READ || IN_LOW_WRITE);
  assign beat_done = state == S_HOLD && cnt == 4'h0;
  assign op_done  = beat_done && (!CFG.wide || beat);

  // state sequencing; setup state skipped and hold wait zeroed when strobe wait is zero
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:   if (start) next_state = first_state(CFG.mux, master);
      S_ALO:    next_state = (CFG.mux == BYTE_ENABLE_OUT_MUX_FULL) ? S_AHI :
                             (CFG.wait_strobe != 4'h0) ? S_SETUP : S_STROBE;
      S_AHI:    next_state = (CFG.wait_strobe != 4'h0) ? S_SETUP : S_STROBE;
      S_SETUP:  if (cnt == 4'h0) next_state = S_STROBE;
      S_STROBE: if (cnt == 4'h0) next_state = S_HOLD;
      S_HOLD:
      begin
        if (cnt == 4'h0)
          next_state = op_done ? S_IDLE : first_state(CFG.mux, master);
      end
      default:  next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // wait counter loaded on each phase entry
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      cnt <= 4'h0;
    else if (next_state != state || (state == S_HOLD && cnt == 4'h0))
    begin
      case (next_state)
        S_SETUP:  cnt <= {2'h0, CFG.wait_setup};
        S_STROBE: cnt <= CFG.wait_strobe;
        S_HOLD:   cnt <= (CFG.wait_strobe != 4'h0) ? {2'h0, CFG.wait_hold} : 4'h0;
        default:  cnt <= 4'h0;
      endcase
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end

  // operation direction and beat tracking
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      is_read <= 1'b0;
      beat    <= 1'b0;
    end
    else if (start)
    begin
      is_read <= IN_LOW_READ;
      beat    <= 1'b0;
    end
    // back to the low beat once the operation ends, so a narrow op never leaves the byte enable armed
    else if (beat_done)
      beat <= ~beat && !op_done;
  end

  // busy stays high for every cycle of the operation; with zero strobe wait it drops for the last one
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      BUSY <= 1'b0;
    else
      BUSY <= next_state != S_IDLE && !(next_state == S_HOLD && CFG.wait_strobe == 4'h0
              && (!CFG.wide || beat || beat_done));
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      CYCLE_DONE <= 1'b0;
    else
      CYCLE_DONE <= op_done;
  end

  // address register; stepping happens once at completion
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      addr <= BYTE_ENABLE_OUT_ADDR_RESET;
    else if (ADDR_LOAD && state == S_IDLE)
      addr <= ADDR_WDATA;
    else if (op_done)
    begin
      case (CFG.step)
        BYTE_ENABLE_OUT_STEP_INC:
          addr <= sel_used ? ((addr & BYTE_ENABLE_OUT_SEL_MASK) | ((addr + 16'h1) & ~BYTE_ENABLE_OUT_SEL_MASK))
                           : addr + 16'h1;
        BYTE_ENABLE_OUT_STEP_DEC:
          addr <= sel_used ? ((addr & BYTE_ENABLE_OUT_SEL_MASK) | ((addr - 16'h1) & ~BYTE_ENABLE_OUT_SEL_MASK))
                           : addr - 16'h1;
        default: addr <= addr;
      endcase
    end
  end

  // outgoing bytes latched from the cpu; the high byte only rides the second beat
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      out_low  <= 8'h00;
      out_high <= 8'h00;
    end
    else
    begin
      if (IN_LOW_WRITE && state == S_IDLE && !BUSY)
        out_low <= CPU_WDATA;
      if (IN_HIGH_WRITE && state == S_IDLE)
        out_high <= CPU_WDATA;
    end
  end

  // captured read data lands in the store; cpu sees it only on a later read
  assign st_wr_en   = master && is_read && state == S_STROBE && cnt == 4'h0;
  assign st_wr_sel  = beat;
  assign st_wr_data = DATA_IN;

  byte_enable_out_data_store #(.WIDTH(8)) u_store (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .wr_en   (st_wr_en),
    .wr_sel  (st_wr_sel),
    .wr_data (st_wr_data),
    .rd_low  (INPUT_DATA_LOW),
    .rd_high (INPUT_DATA_HIGH)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      ADDR_VALUE <= BYTE_ENABLE_OUT_ADDR_RESET;
    else
      ADDR_VALUE <= addr;
  end

  // pin drive, registered from the next state so pins track the phase exactly
  logic [15:0] addr_hi_masked;
  logic        lat_lo;
  logic        lat_hi;
  logic        strobe_on;
  logic [15:0] next_addr_out;

  always_comb
  begin
    addr_hi_masked = sel_used ? (addr & ~BYTE_ENABLE_OUT_SEL_MASK) : addr;
    lat_lo    = next_state == S_ALO;
    lat_hi    = next_state == S_AHI;
    strobe_on = next_state == S_STROBE;
    next_addr_out = addr;
    if (sel_used)
      next_addr_out[BYTE_ENABLE_OUT_SELECT_BIT] = next_state != S_IDLE;
    if (master && CFG.mux == BYTE_ENABLE_OUT_MUX_PARTIAL)
      next_addr_out[0] = lat_lo;
    if (master && CFG.mux == BYTE_ENABLE_OUT_MUX_FULL)
      next_addr_out[1:0] = {lat_hi, lat_lo};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      DATA_OUT <= 8'h00;
      DATA_OE  <= 1'b0;
      ADDR_OUT <= BYTE_ENABLE_OUT_ADDR_RESET;
    end
    else
    begin
      ADDR_OUT <= next_addr_out;
      DATA_OE  <= lat_lo || lat_hi || (!is_read && !start && next_state inside {S_SETUP, S_STROBE, S_HOLD})
                  || (start && IN_LOW_WRITE && !lat_lo);
      if (lat_lo)
        DATA_OUT <= addr[7:0];
      else if (lat_hi)
        DATA_OUT <= addr_hi_masked[15:8];
      else
        DATA_OUT <= (beat ^ beat_done) && CFG.wide ? out_high : (start ? CPU_WDATA : out_low);
    end
  end

  // control pins with polarity; mode 1 shares one pin for direction, one for enable
  logic rd_act;
  logic wr_act;
  logic rw_dir;
  logic active;
  logic dir_read;

  always_comb
  begin
    active   = next_state != S_IDLE;
    dir_read = start ? IN_LOW_READ : is_read;
    rd_act   = 1'b0;
    wr_act   = 1'b0;
    rw_dir   = 1'b0;
    if (CFG.mode == BYTE_ENABLE_OUT_MODE_MASTER2)
    begin
      rd_act = strobe_on && dir_read;
      wr_act = strobe_on && !dir_read;
    end
    else
    begin
      rw_dir = active && dir_read;
      wr_act = strobe_on;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      CTL <= '0;
    else
    begin
      CTL.read_strobe_out  <= (CFG.mode == BYTE_ENABLE_OUT_MODE_MASTER2 ? rd_act : rw_dir) ^ ~CFG.rd_pol;
      CTL.write_strobe_out <= wr_act ^ ~CFG.wr_pol;
      CTL.byte_enable_out  <= (active && CFG.wide && (beat ^ beat_done)) ^ ~CFG.be_pol;
      CTL.port_select_line <= (sel_used && active) ^ ~CFG.cs_pol;
      CTL.addr_pin_zero    <= lat_lo ^ ~CFG.al_pol;
      CTL.addr_pin_one     <= lat_hi ^ ~CFG.al_pol;
    end
  end

endmodule : byte_enable_out_engine
`default_nettype wire

// >>> tb/byte_enable_out_engine_sva.sv
// port assertions for the parallel master bus engine
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module byte_enable_out_engine_sva
  import byte_enable_out_pkg::*;
(
  // clock and reset
  input wire logic         CORE_CLK,
  input wire logic         SYS_RST,
  // watched ports
  input wire logic         PORT_ENABLE,
  input wire byte_enable_out_cfg_type CFG,
  input wire logic         ADDR_LOAD,
  input wire logic [15:0]  ADDR_VALUE,
  input wire logic         BUSY,
  input wire logic         CYCLE_DONE,
  input wire byte_enable_out_ctl_type CTL
);
  logic [15:0]  prev_addr;
  logic         prev_ld;
  logic         prev_ld2;
  logic         prev_rst;
  byte_enable_out_cfg_type prev_cfg;
  logic         quiet;
  logic         stepped;
  always_ff @(posedge CORE_CLK)
  begin
    prev_addr <= ADDR_VALUE;
    prev_ld   <= ADDR_LOAD;
    prev_ld2  <= prev_ld;
    prev_rst  <= SYS_RST;
    prev_cfg  <= CFG;
  end
  // registered pins lag the config by a cycle, so judge them only once it has settled
  assign quiet   = CFG == prev_cfg && !prev_rst;
  // a load reaches ADDR_VALUE two edges after the strobe, so both delays are masked
  assign stepped = ADDR_VALUE != prev_addr && !prev_ld && !prev_ld2 && !prev_rst;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  done_pulse_a: assert property (CYCLE_DONE |=> !CYCLE_DONE) else $error("done pulse too long");
  done_idle_a: assert property (CYCLE_DONE |-> !BUSY && $past(BUSY, 2)) else $error("done without busy");
  step_idle_a: assert property (stepped |-> !BUSY) else $error("address stepped while busy");
  sel_kept_a: assert property (stepped && CFG.csf == BYTE_ENABLE_OUT_CSF_SELECT |-> ADDR_VALUE[15:14] == prev_addr[15:14])
    else $error("select bits stepped");
  idle_slave_a: assert property (!BUSY && !(PORT_ENABLE && CFG.mode[1]) |=> !BUSY)
    else $error("busy outside master");
  low_latch_a: assert property (quiet && CFG.mux == BYTE_ENABLE_OUT_MUX_DEMUX |-> CTL.addr_pin_zero == !CFG.al_pol)
    else $error("low latch active");
  high_latch_a: assert property (quiet && CFG.mux != BYTE_ENABLE_OUT_MUX_FULL |-> CTL.addr_pin_one == !CFG.al_pol)
    else $error("high latch active");
  be_narrow_a: assert property (quiet && !CFG.wide |-> CTL.byte_enable_out == !CFG.be_pol)
    else $error("byte enable in narrow mode");
  cover property (CYCLE_DONE && CFG.wide);
  cover property (CYCLE_DONE && CFG.mux == BYTE_ENABLE_OUT_MUX_FULL);
  cover property (BUSY && CFG.wait_strobe != 4'h0);
endmodule : byte_enable_out_engine_sva
bind byte_enable_out_engine byte_enable_out_engine_sva u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PORT_ENABLE(PORT_ENABLE),
  .CFG(CFG), .ADDR_LOAD(ADDR_LOAD), .ADDR_VALUE(ADDR_VALUE), .BUSY(BUSY), .CYCLE_DONE(CYCLE_DONE), .CTL(CTL));
`default_nettype wire

// >>> tb/byte_enable_out_mem_model.sv
// behavioural memory on the far side of the parallel bus
// assumes the bench feeds it the engine pins and configuration
`timescale 1ns/1ps
`default_nettype none
module byte_enable_out_mem_model
  import byte_enable_out_pkg::*;
(
  // clock and setup
  input  wire logic         clk,
  input  wire byte_enable_out_cfg_type cfg,
  input  wire logic         slow,
  // engine pins
  input  wire byte_enable_out_ctl_type ctl,
  input  wire logic [15:0]  addr_out,
  input  wire logic [7:0]   data_out,
  input  wire logic         data_oe,
  output logic [7:0]        rdata
);
  logic [7:0] mem [512];
  logic [7:0] alat;
  logic [7:0] last;
  logic       dir;
  logic       en;
  logic       rd;
  logic       wr;
  logic       ph;
  logic       sel;
  logic [8:0] adr;
  always_comb
  begin
    dir   = ctl.read_strobe_out ~^ cfg.rd_pol;
    en    = ctl.write_strobe_out ~^ cfg.wr_pol;
    // with the select line in use the part answers only while both select forms are active
    sel   = cfg.csf != BYTE_ENABLE_OUT_CSF_SELECT
            || ((ctl.port_select_line ~^ cfg.cs_pol) && addr_out[BYTE_ENABLE_OUT_SELECT_BIT]);
    rd    = sel && (cfg.mode == BYTE_ENABLE_OUT_MODE_MASTER1 ? dir & en : dir);
    wr    = sel && data_oe && (cfg.mode == BYTE_ENABLE_OUT_MODE_MASTER1 ? ~dir & en : en);
    adr   = {ctl.byte_enable_out ~^ cfg.be_pol, cfg.mux == BYTE_ENABLE_OUT_MUX_DEMUX ? addr_out[7:0] : alat};
    // a slow part answers a cycle late; released lines toggle so stale data never passes
    rdata = rd && !data_oe && (ph || !slow) ? mem[adr] : ~last;
  end
  always_ff @(posedge clk)
  begin
    if ((ctl.addr_pin_zero ~^ cfg.al_pol) && cfg.mux != BYTE_ENABLE_OUT_MUX_DEMUX && data_oe)
      alat <= data_out;
    if (wr)
      mem[adr] <= data_out;
    ph   <= rd;
    last <= rdata;
  end
endmodule : byte_enable_out_mem_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the parallel master bus engine
// assumes the package, engine, checker and memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import byte_enable_out_pkg::*;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [15:0] adr;} byte_enable_out_note_type;
  logic          core_clk;
  logic          sys_rst;
  logic          port_en;
  byte_enable_out_cfg_type  cfg;
  logic [2:0]    req;
  logic [7:0]    wdata;
  logic          ld;
  logic [15:0]   ld_val;
  logic          slow;
  logic [7:0]    din_lo;
  logic [7:0]    din_hi;
  logic [15:0]   addr_v;
  logic          busy;
  logic          done;
  logic [7:0]    rdata;
  logic [7:0]    dout;
  logic          oe;
  logic [15:0]   aout;
  byte_enable_out_ctl_type  ctl;
  byte_enable_out_note_type notes[$];
  byte_enable_out_note_type mt;
  int            num_errors;
  int            comparisons;
  integer        seed;
  logic [7:0]    lo;
  logic [7:0]    hi;
  logic [7:0]    exp_lo;
  logic [7:0]    exp_hi;
  logic [15:0]   a;
  logic [31:0]   r;
  byte_enable_out_engine dut
  (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PORT_ENABLE(port_en), .CFG(cfg), .IN_LOW_READ(req[0]),
    .IN_LOW_WRITE(req[1]), .IN_HIGH_WRITE(req[2]), .CPU_WDATA(wdata), .ADDR_LOAD(ld), .ADDR_WDATA(ld_val),
    .INPUT_DATA_LOW(din_lo), .INPUT_DATA_HIGH(din_hi), .ADDR_VALUE(addr_v), .BUSY(busy), .CYCLE_DONE(done),
    .DATA_IN(rdata), .DATA_OUT(dout), .DATA_OE(oe), .ADDR_OUT(aout), .CTL(ctl)
  );
  byte_enable_out_mem_model u_mem (.clk(core_clk), .cfg(cfg), .slow(slow), .ctl(ctl), .addr_out(aout), .data_out(dout),
    .data_oe(oe), .rdata(rdata));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  function automatic logic [15:0] step_of(input logic [15:0] v);
    logic [15:0] n;
    n = cfg.step == BYTE_ENABLE_OUT_STEP_INC ? v + 16'h0001 : cfg.step == BYTE_ENABLE_OUT_STEP_DEC ? v - 16'h0001 : v;
    return cfg.csf == BYTE_ENABLE_OUT_CSF_SELECT ? {v[15:14], n[13:0]} : n;
  endfunction : step_of
  // one operation at the loaded address; a read also retries while busy, which must be ignored
  task automatic op(input logic rd);
    int n;
    ld     <= 1'b1;
    ld_val <= a;
    @(posedge core_clk);
    ld <= 1'b0;
    // the input bytes only change on bus reads; a write leaves the last read result standing
    if (rd)
    begin
      exp_lo = lo;
      if (cfg.wide)
        exp_hi = hi;
    end
    notes.push_back('{exp_lo, exp_hi, step_of(a)});
    if (cfg.wide && !rd)
    begin
      req   <= 3'h4;
      wdata <= hi;
      @(posedge core_clk);
    end
    req   <= rd ? 3'h1 : 3'h2;
    wdata <= lo;
    @(posedge core_clk);
    if (rd)
      @(posedge core_clk);
    req <= 3'h0;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 300)
    begin
      num_errors++;
      $display("ERROR done expected 1 seen 0");
      test_done();
    end
    repeat (4) @(posedge core_clk);
  endtask : op
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    forever
    begin
      @(posedge core_clk);
      if (done === 1'b1)
      begin
        repeat (3) @(posedge core_clk);
        if (notes.size() == 0)
        begin
          num_errors++;
          $display("ERROR done expected 0 seen 1");
        end
        else
        begin
          mt = notes.pop_front();
          check("data_low", mt.lo, din_lo);
          check("data_high", mt.hi, din_hi);
          check("address", mt.adr, addr_v);
        end
      end
    end
  end
  initial
  begin
    seed    = 32'hFB7F;
    sys_rst = 1'b1;
    port_en = 1'b1;
    cfg     = '{mode: BYTE_ENABLE_OUT_MODE_MASTER2, al_pol: 1'b1, cs_pol: 1'b1, be_pol: 1'b1, wr_pol: 1'b1, rd_pol: 1'b1,
                default: '0};
    {req, wdata, ld, ld_val, slow, hi, exp_lo, exp_hi} = '0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 30; i++)
    begin
      r = $random(seed);
      a = 16'($random(seed));
      cfg  <= '{mode: {1'b1, r[0]}, wide: r[1], step: r[3:2] % 2'h3, mux: r[5:4] % 2'h3,
               csf: r[6] ? BYTE_ENABLE_OUT_CSF_SELECT : 2'h0, al_pol: r[7], cs_pol: r[8], be_pol: r[9], wr_pol: r[10],
               rd_pol: r[11], wait_setup: r[13:12], wait_strobe: r[17:14], wait_hold: r[19:18]};
      slow <= r[20] && r[17:15] != 3'h0;
      lo = r[27:20];
      if (r[1])
        hi = r[31:24];
      @(posedge core_clk);
      op(1'b0);
      op(1'b1);
      $display("test %0d done", i);
    end
    port_en <= 1'b0;
    req     <= 3'h1;
    @(posedge core_clk);
    port_en  <= 1'b1;
    cfg.mode <= 2'h1;
    req      <= 3'h2;
    @(posedge core_clk);
    req <= 3'h0;
    repeat (20) @(posedge core_clk);
    check("busy", 16'h0000, {15'h0000, busy});
    $display("test idle done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
